// ---- pkg/ebus_defs.svh ----
// Constants of the external bus cycle master: codes, resets, counts.
// Assumes inclusion by bare name from the design file only.
// How it works
// - Odd word or long operands refused, no cycle
// - Odd address moves one byte only
// - Byte port splits operand into byte cycles
// - Port width decoded as 8 or 16
// - Start, direction, space and size driven out
// - Separate address and data strobes
// - Async and sync cycles on both widths
// - Async inputs pass a synchroniser first
// - Sync cycle completes in three clocks
// - Fast termination completes in two clocks
// - Inputs captured once per clock edge
// - Captured ack and fault levels resolved before use, async cycles only
// - Same protocol whoever owns the bus
// - Size code gives bytes still remaining
// - Address strobe follows cycle start
`ifndef EBUS_DEFS_SVH
`define EBUS_DEFS_SVH
`define EB_SIZE_BYTE 2'h1
`define EB_ACK_PORT8 2'h2
`define EB_ACK_NONE 2'h3
`define EB_SPACE_RST 4'h0
`define EB_SYNC_CLKS 3'h3
`define EB_FAST_CLKS 3'h2
`endif

// ---- pkg/ebus_pkg.sv ----
// Types of the external bus cycle master.
// Assumes the constants header sits beside it.
package ebus_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_STRB = 5'h04,
        ST_WAIT = 5'h08,
        ST_SPARE = 5'h10
    } state_t;

    typedef struct packed {
        state_t st;
        logic [31:0] addr;
        logic [2:0] rem;
        logic [31:0] wrSh;
        logic [31:0] rdAcc;
        logic write;
        logic [3:0] space;
        logic fast;
        logic fastP8;
        logic syncMode;
        logic armed;
        logic [1:0] ackSy1;
        logic [1:0] ackSy2;
        logic [1:0] ackSy3;
        logic [1:0] ackSt;
        logic fltSy1;
        logic fltSy2;
        logic fltSy3;
        logic fltSt;
        logic [15:0] dSy1;
        logic [15:0] dSy2;
        logic [15:0] dSy3;
        logic asN;
        logic dsN;
        logic start;
        logic doe;
        logic [15:0] dout;
        logic ready;
        logic rspV;
        logic [31:0] rspData;
        logic rspFault;
        logic rspMis;
        logic [2:0] cyc;
    } state_s_t;
endpackage

// ---- verilog/external_bus_cycle_interface.sv ----
// Master side of the external parallel bus: sized, aligned operand
// transfers split into bus cycles on 8-bit or 16-bit ports.
// Assumes one request at a time from the core and a bus slave that
// drives the acknowledge and fault inputs low.
`timescale 1ns/100ps
`include "ebus_defs.svh"

module external_bus_cycle_interface (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Operand request from the core
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [31:0] reqAddr,
    input wire logic [1:0] reqSize,
    input wire logic [3:0] reqSpace,
    input wire logic [31:0] reqWrData,
    input wire logic reqSync,
    input wire logic reqFast,
    input wire logic reqFastPort8,
    output logic reqReady,
    // Operand answer
    output logic rspValid,
    output logic [31:0] rspRdData,
    output logic rspFault,
    output logic rspMisalign,
    // Bus outputs
    output logic cycleStart,
    output logic [31:0] busAddr,
    output logic [3:0] space_code,
    output logic xfer_size_hi,
    output logic xfer_size_lo,
    output logic readNotWrite,
    output logic addr_valid_strobe_n,
    output logic data_valid_strobe_n,
    // Data bus, three signals
    input wire logic [15:0] busDataIn,
    output logic [15:0] busDataOut,
    output logic busDataOe,
    // Termination inputs
    input wire logic port_ack_hi_n,
    input wire logic port_ack_lo_n,
    input wire logic bus_fault_in_n
);

    ebus_pkg::state_s_t q;
    ebus_pkg::state_s_t d;

    logic [1:0] ackEff;
    logic fltEff;
    logic [15:0] dinEff;
    logic ackHit;
    logic fltHit;
    logic done;
    logic p8;
    logic k1;
    logic [7:0] byteIn;
    logic [2:0] kBytes;
    logic live;

    // ------------------------------------------------------------
    // Termination decode
    // ------------------------------------------------------------
    // Sync cycles read the pins straight, async ones the resolved ack and fault and the stage-three data copy
    always_comb begin
        ackEff = q.syncMode ? {port_ack_hi_n, port_ack_lo_n} : q.ackSt;
        fltEff = q.syncMode ? bus_fault_in_n : q.fltSt;
        dinEff = q.syncMode ? busDataIn : q.dSy3;
        // Async pins count only once the stale acknowledge has drained
        live = q.syncMode || q.armed;
        ackHit = (ackEff != `EB_ACK_NONE) && live;
        fltHit = !fltEff && live;
        done = (q.st == ebus_pkg::ST_STRB && q.fast) ||
               (q.st == ebus_pkg::ST_WAIT && ackHit && !fltHit);
        p8 = q.fast ? q.fastP8 : (ackEff == `EB_ACK_PORT8);
        k1 = q.addr[0] || p8 || (q.rem == 3'h1);
        kBytes = k1 ? 3'h1 : 3'h2;
        byteIn = (q.addr[0] && !p8) ? dinEff[7:0] : dinEff[15:8];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Both-low acknowledge counts as a 16-bit port, the widest here
    always_comb begin
        d = q;
        d.start = 1'b0;
        d.rspV = 1'b0;
        // Three stages; stage one feeds only stage two
        d.ackSy1 = {port_ack_hi_n, port_ack_lo_n};
        d.ackSy2 = q.ackSy1;
        d.ackSy3 = q.ackSy2;
        d.fltSy1 = bus_fault_in_n;
        d.fltSy2 = q.fltSy1;
        d.fltSy3 = q.fltSy2;
        d.dSy1 = busDataIn;
        d.dSy2 = q.dSy1;
        d.dSy3 = q.dSy2;
        // A level counts once two stages agree
        if (q.ackSy2 == q.ackSy3) begin
            d.ackSt = q.ackSy3;
        end
        if (q.fltSy2 == q.fltSy3) begin
            d.fltSt = q.fltSy3;
        end
        // Arm only after a negated level reaches stage three, so a slave
        // still releasing the last cycle cannot end the next one early
        d.armed = q.armed || (q.ackSy3 == `EB_ACK_NONE && q.fltSy3);
        // Clock count restarts with every bus cycle, not every operand
        d.cyc = (q.st == ebus_pkg::ST_IDLE || done) ? 3'h0 :
                q.cyc + 3'h1;
        case (q.st)
            ebus_pkg::ST_IDLE: begin
                if (reqValid && q.ready) begin
                    if (reqSize != `EB_SIZE_BYTE && reqAddr[0]) begin
                        d.rspV = 1'b1;
                        d.rspMis = 1'b1;
                        d.rspFault = 1'b0;
                    end else begin
                        d.st = ebus_pkg::ST_ADDR;
                        d.addr = reqAddr;
                        d.rem = {reqSize == 2'h0, reqSize};
                        d.write = reqWrite;
                        d.space = reqSpace;
                        d.fast = reqFast;
                        d.fastP8 = reqFastPort8;
                        d.syncMode = reqSync || reqFast;
                        d.armed = 1'b0;
                        d.rdAcc = 32'h0000_0000;
                        d.rspMis = 1'b0;
                        d.rspFault = 1'b0;
                        // Left-justify so the top byte leaves first
                        case (reqSize)
                            2'h1: d.wrSh = {reqWrData[7:0], 24'h00_0000};
                            2'h2: d.wrSh = {reqWrData[15:0], 16'h0000};
                            2'h3: d.wrSh = {reqWrData[23:0], 8'h00};
                            default: d.wrSh = reqWrData;
                        endcase
                    end
                end
            end
            ebus_pkg::ST_ADDR: begin
                d.st = ebus_pkg::ST_STRB;
            end
            ebus_pkg::ST_STRB: begin
                if (!q.fast) begin
                    d.st = ebus_pkg::ST_WAIT;
                end
            end
            ebus_pkg::ST_WAIT: begin
                // Fault wins over an acknowledge in the same clock
                if (fltHit) begin
                    d.st = ebus_pkg::ST_IDLE;
                    d.rspV = 1'b1;
                    d.rspFault = 1'b1;
                    d.rspData = q.rdAcc;
                end
            end
            default: begin
                d.st = ebus_pkg::ST_IDLE;
            end
        endcase
        // Each completed cycle moves one or two bytes
        if (done) begin
            d.rdAcc = k1 ? {q.rdAcc[23:0], byteIn} :
                           {q.rdAcc[15:0], dinEff};
            d.wrSh = k1 ? {q.wrSh[23:0], 8'h00} : {q.wrSh[15:0], 16'h0000};
            d.rem = q.rem - kBytes;
            d.addr = q.addr + {29'h0, kBytes};
            d.armed = 1'b0;
            if (q.rem == kBytes) begin
                d.st = ebus_pkg::ST_IDLE;
                d.rspV = 1'b1;
                d.rspData = d.rdAcc;
            end else begin
                d.st = ebus_pkg::ST_ADDR;
            end
        end
        // Output copies follow the next state so pins come from flops
        d.start = (d.st == ebus_pkg::ST_ADDR);
        d.asN = !(d.st == ebus_pkg::ST_STRB ||
                  d.st == ebus_pkg::ST_WAIT);
        d.dsN = !((d.st == ebus_pkg::ST_STRB && (!d.write || d.fast)) ||
                  d.st == ebus_pkg::ST_WAIT);
        d.doe = d.write && (d.st != ebus_pkg::ST_IDLE);
        // A byte at an odd address goes out on both halves of the data bus
        d.dout = d.addr[0] ? {d.wrSh[31:24], d.wrSh[31:24]} :
                             d.wrSh[31:16];
        d.ready = (d.st == ebus_pkg::ST_IDLE);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Strobes and acknowledge copies reset to their negated level
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
            q.st <= ebus_pkg::ST_IDLE;
            q.space <= `EB_SPACE_RST;
            q.ackSy1 <= `EB_ACK_NONE;
            q.ackSy2 <= `EB_ACK_NONE;
            q.ackSy3 <= `EB_ACK_NONE;
            q.ackSt <= `EB_ACK_NONE;
            q.fltSy1 <= 1'b1;
            q.fltSy2 <= 1'b1;
            q.fltSy3 <= 1'b1;
            q.fltSt <= 1'b1;
            q.asN <= 1'b1;
            q.dsN <= 1'b1;
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Pins straight from the state flops
    assign reqReady = q.ready;
    assign rspValid = q.rspV;
    assign rspRdData = q.rspData;
    assign rspFault = q.rspFault;
    assign rspMisalign = q.rspMis;
    assign cycleStart = q.start;
    assign busAddr = q.addr;
    assign space_code = q.space;
    assign xfer_size_hi = q.rem[1];
    assign xfer_size_lo = q.rem[0];
    assign readNotWrite = !q.write;
    assign addr_valid_strobe_n = q.asN;
    assign data_valid_strobe_n = q.dsN;
    assign busDataOut = q.dout;
    assign busDataOe = q.doe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_misalign_refused: assert property (@(posedge core_clk)
        disable iff (rst)
        (reqValid && q.ready && reqSize != `EB_SIZE_BYTE && reqAddr[0])
        |=> (q.rspV && q.rspMis && q.asN))
        else $error("misaligned operand not refused");

    a_hold_outputs: assert property (@(posedge core_clk)
        disable iff (rst)
        (q.st == ebus_pkg::ST_WAIT) |->
        ($stable(q.addr) && $stable(q.rem) && $stable(q.space) &&
         $stable(q.write)))
        else $error("cycle outputs moved before termination");

    a_strobe_follows: assert property (@(posedge core_clk)
        disable iff (rst)
        q.start |=> (!q.asN && !q.start))
        else $error("address strobe late after start");

    a_fast_two: assert property (@(posedge core_clk)
        disable iff (rst)
        (q.start && q.fast) |=> !q.asN ##1 q.asN)
        else $error("fast cycle not two clocks");

    a_sync_three: assert property (@(posedge core_clk)
        disable iff (rst)
        (q.start && q.syncMode && !q.fast) ##2
        ({port_ack_hi_n, port_ack_lo_n} != `EB_ACK_NONE &&
         bus_fault_in_n) |=> q.asN)
        else $error("sync cycle not three clocks");

    a_write_strobe: assert property (@(posedge core_clk)
        disable iff (rst)
        (q.start && q.write && !q.fast) |=> q.dsN ##1 !q.dsN)
        else $error("write data strobe timing wrong");

    a_sync_agree: assert property (@(posedge core_clk)
        disable iff (rst)
        !$stable(q.ackSt) |-> (q.ackSt == $past(q.ackSy3) &&
                               $past(q.ackSy2) == $past(q.ackSy3)))
        else $error("ack level taken before stages agreed");

    a_last_byte: assert property (@(posedge core_clk)
        disable iff (rst)
        (q.st == ebus_pkg::ST_WAIT && ackHit && !fltHit &&
         q.rem == 3'h1) |=> (q.rspV && q.ready))
        else $error("size code one did not end operand");

    a_byte_split: assert property (@(posedge core_clk)
        disable iff (rst)
        (q.st == ebus_pkg::ST_WAIT && ackHit && ackEff == `EB_ACK_PORT8 &&
         !fltHit && q.rem > 3'h1) |=>
        (q.st == ebus_pkg::ST_ADDR && q.rem == $past(q.rem) - 3'h1))
        else $error("byte port split wrong");

    a_cycle_bound: assert property (@(posedge core_clk)
        disable iff (rst)
        (q.st == ebus_pkg::ST_STRB) |-> (q.cyc == `EB_FAST_CLKS - 3'h1))
        else $error("strobe phase not second clock");

    a_odd_single: assert property (@(posedge core_clk)
        disable iff (rst)
        (q.st == ebus_pkg::ST_WAIT && ackHit && !fltHit && q.addr[0])
        |=> (q.rem == $past(q.rem) - 3'h1))
        else $error("odd address moved more than one byte");

    a_stale_ack: assert property (@(posedge core_clk)
        disable iff (rst)
        (q.st == ebus_pkg::ST_WAIT && !q.syncMode && !q.armed)
        |=> (q.st == ebus_pkg::ST_WAIT))
        else $error("async cycle ended on a stale acknowledge");

endmodule

// ---- verif/bus_slave_model.sv ----
// Behavioural bus slave that ends each cycle with acks or a fault after a delay.
// Assumes the master's strobe and address come straight from flops.
`timescale 1ns/100ps

module bus_slave_model (
    // Clock
    input wire logic core_clk,
    // Master side
    input wire logic addr_valid_strobe_n,
    input wire logic [31:0] busAddr,
    // Behaviour set by the bench
    input wire logic port8,
    input wire logic [3:0] ackDelay,
    input wire logic giveFault,
    // Answers
    output logic port_ack_hi_n,
    output logic port_ack_lo_n,
    output logic bus_fault_in_n,
    output logic [15:0] busDataIn
);
    // ------------------------------------------------------------
    // Data and termination
    // ------------------------------------------------------------
    logic [3:0] cnt;
    logic done;
    logic [15:0] lastQ;
    logic [15:0] val;

    initial begin
        cnt = 4'h0;
        done = 1'b0;
        lastQ = 16'h0000;
        port_ack_hi_n = 1'b1;
        port_ack_lo_n = 1'b1;
        bus_fault_in_n = 1'b1;
    end

    // Byte at address a holds a[7:0]; unused lanes never look valid
    always_comb begin
        if (port8) val = {busAddr[7:0], ~lastQ[7:0]};
        else if (busAddr[0]) val = {~lastQ[15:8], busAddr[7:0]};
        else val = {busAddr[7:0], busAddr[7:0] + 8'h01};
        busDataIn = addr_valid_strobe_n ? ~lastQ : val;
    end

    // Outputs move only after a rising edge and hold until the strobe
    // negates, so the master never samples a line in motion
    always @(posedge core_clk) begin
        if (!addr_valid_strobe_n) lastQ <= val;
        if (addr_valid_strobe_n) begin
            cnt <= 4'h0;
            done <= 1'b0;
            port_ack_hi_n <= 1'b1;
            port_ack_lo_n <= 1'b1;
            bus_fault_in_n <= 1'b1;
        end else if (!done && cnt == ackDelay) begin
            done <= 1'b1;
            bus_fault_in_n <= ~giveFault;
            port_ack_hi_n <= giveFault | port8;
            port_ack_lo_n <= giveFault;
        end else if (!done) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// ---- verif/tb_external_bus_cycle_interface.sv ----
// Self-checking bench for the external bus cycle master.
// Assumes the slave model file is compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_errors++; $display("unexpected at %0t: got %0h want %0h", \
    $time, g, e); end end

module tb_external_bus_cycle_interface;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reqValid = 1'b0, reqWrite = 1'b0, reqSync = 1'b0;
    logic reqFast = 1'b0, reqFastPort8 = 1'b0;
    logic [31:0] reqAddr = 32'h0, reqWrData = 32'h0;
    logic [1:0] reqSize = 2'h1;
    logic [3:0] reqSpace = 4'h0, ackDelay = 4'h0;
    logic port8 = 1'b0, giveFault = 1'b0;
    logic reqReady, rspValid, rspFault, rspMisalign, cycleStart;
    logic [31:0] rspRdData, busAddr;
    logic [3:0] space_code;
    logic xfer_size_hi, xfer_size_lo, readNotWrite, busDataOe;
    logic addr_valid_strobe_n, data_valid_strobe_n;
    logic [15:0] busDataIn, busDataOut;
    logic port_ack_hi_n, port_ack_lo_n, bus_fault_in_n;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    logic [31:0] qa[$];
    logic [1:0] qs[$];
    logic [3:0] qsp[$];
    logic qr[$], qoe[$];
    logic [15:0] qd[$];
    int qt[$];

    always #4 core_clk = ~core_clk;

    external_bus_cycle_interface u_external_bus_cycle_interface (
        .core_clk(core_clk), .rst(rst), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqSize(reqSize),
        .reqSpace(reqSpace), .reqWrData(reqWrData), .reqSync(reqSync),
        .reqFast(reqFast), .reqFastPort8(reqFastPort8),
        .reqReady(reqReady), .rspValid(rspValid), .rspRdData(rspRdData),
        .rspFault(rspFault), .rspMisalign(rspMisalign),
        .cycleStart(cycleStart), .busAddr(busAddr),
        .space_code(space_code), .xfer_size_hi(xfer_size_hi),
        .xfer_size_lo(xfer_size_lo), .readNotWrite(readNotWrite),
        .addr_valid_strobe_n(addr_valid_strobe_n),
        .data_valid_strobe_n(data_valid_strobe_n),
        .busDataIn(busDataIn), .busDataOut(busDataOut),
        .busDataOe(busDataOe), .port_ack_hi_n(port_ack_hi_n),
        .port_ack_lo_n(port_ack_lo_n), .bus_fault_in_n(bus_fault_in_n));

    bus_slave_model u_bus_slave_model (
        .core_clk(core_clk), .addr_valid_strobe_n(addr_valid_strobe_n),
        .busAddr(busAddr), .port8(port8), .ackDelay(ackDelay),
        .giveFault(giveFault), .port_ack_hi_n(port_ack_hi_n),
        .port_ack_lo_n(port_ack_lo_n), .bus_fault_in_n(bus_fault_in_n),
        .busDataIn(busDataIn));

    // ------------------------------------------------------------
    // Bus monitor and hang guard
    // ------------------------------------------------------------
    // Records each bus cycle mid-way through its start clock, where the
    // flopped outputs have long settled
    always @(negedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc > 4000) begin
            n_errors++;
            complete_run();
        end
        if (cycleStart === 1'b1) begin
            `CHK(addr_valid_strobe_n, 1'b1)
            qa.push_back(busAddr);
            qs.push_back({xfer_size_hi, xfer_size_lo});
            qsp.push_back(space_code);
            qr.push_back(readNotWrite);
            qoe.push_back(busDataOe);
            qd.push_back(busDataOut);
            qt.push_back(cyc);
        end
    end

    task automatic complete_run();
        $display("checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // One operand request, held until taken, then a bounded answer wait
    task automatic op(input logic w, input logic [31:0] a,
        input logic [1:0] sz, input logic sy, input logic fa);
        int k;
        qa.delete(); qs.delete(); qsp.delete();
        qr.delete(); qoe.delete(); qt.delete(); qd.delete();
        @(posedge core_clk);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqAddr <= a;
        reqSize <= sz;
        reqSync <= sy;
        reqFast <= fa;
        // Ready is a flop: seen high just after an edge, the next edge takes it
        #1;
        while (reqReady !== 1'b1) begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        reqValid <= 1'b0;
        // A refusal stands only in the clock right after the take
        for (k = 0; k < 300; k++) begin
            #1;
            if (rspValid === 1'b1) break;
            @(posedge core_clk);
        end
        `CHK(k < 300, 1'b1)
    endtask

    // Count, first address, size codes, address step and clock gap
    task automatic chk_seq(input int n, input logic [31:0] a0,
        input logic [1:0] s0, input logic [1:0] s1, input int st,
        input int gap);
        `CHK(qa.size(), n)
        if (qa.size() > 0) `CHK(qa[0], a0)
        if (qa.size() > 0) `CHK(qs[0], s0)
        if (qa.size() > 1) `CHK(qs[1], s1)
        if (qa.size() > 1) `CHK(qa[1], a0 + st)
        if (qa.size() > 1 && gap > 0) `CHK(qt[1] - qt[0], gap)
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_sync_long();
        op(1'b0, 32'h40, 2'h0, 1'b1, 1'b0);
        `CHK(rspRdData, 32'h40414243)
        chk_seq(2, 32'h40, 2'h0, 2'h2, 2, 3);
        $display("t_sync_long done");
    endtask

    task automatic t_async_byte_port();
        port8 = 1'b1;
        ackDelay = 4'h2;
        op(1'b0, 32'h40, 2'h2, 1'b0, 1'b0);
        `CHK(rspRdData[15:0], 16'h4041)
        chk_seq(2, 32'h40, 2'h2, 2'h1, 1, 0);
        op(1'b0, 32'h43, 2'h1, 1'b1, 1'b0);
        `CHK(rspRdData[7:0], 8'h43)
        port8 = 1'b0;
        op(1'b0, 32'h43, 2'h1, 1'b1, 1'b0);
        `CHK(rspRdData[7:0], 8'h43)
        chk_seq(1, 32'h43, 2'h1, 2'h1, 1, 0);
        ackDelay = 4'h0;
        $display("t_async_byte_port done");
    endtask

    task automatic t_misalign();
        op(1'b0, 32'h41, 2'h2, 1'b1, 1'b0);
        `CHK(rspMisalign, 1'b1)
        `CHK(qa.size(), 0)
        op(1'b0, 32'h41, 2'h0, 1'b1, 1'b0);
        `CHK(rspMisalign, 1'b1)
        $display("t_misalign done");
    endtask

    task automatic t_fast();
        reqFastPort8 <= 1'b1;
        port8 = 1'b1;
        op(1'b0, 32'h40, 2'h2, 1'b1, 1'b1);
        `CHK(rspRdData[15:0], 16'h4041)
        chk_seq(2, 32'h40, 2'h2, 2'h1, 1, 2);
        reqFastPort8 <= 1'b0;
        port8 = 1'b0;
        op(1'b0, 32'h40, 2'h0, 1'b1, 1'b1);
        `CHK(rspRdData, 32'h40414243)
        chk_seq(2, 32'h40, 2'h0, 2'h2, 2, 2);
        $display("t_fast done");
    endtask

    task automatic t_fault();
        giveFault = 1'b1;
        op(1'b0, 32'h40, 2'h0, 1'b1, 1'b0);
        `CHK(rspFault, 1'b1)
        giveFault = 1'b0;
        op(1'b0, 32'h40, 2'h2, 1'b1, 1'b0);
        `CHK(rspFault, 1'b0)
        $display("t_fault done");
    endtask

    task automatic t_write();
        reqSpace <= 4'h5;
        reqWrData <= 32'h11223344;
        ackDelay = 4'h1;
        op(1'b1, 32'h80, 2'h0, 1'b0, 1'b0);
        chk_seq(2, 32'h80, 2'h0, 2'h2, 2, 0);
        if (qa.size() > 1) `CHK(qr[1], 1'b0)
        if (qa.size() > 0) `CHK(qsp[0], 4'h5)
        if (qa.size() > 0) `CHK(qoe[0], 1'b1)
        if (qd.size() > 1) `CHK(qd[0], 16'h1122)
        if (qd.size() > 1) `CHK(qd[1], 16'h3344)
        `CHK(data_valid_strobe_n, 1'b1)
        reqWrData <= 32'h0000_00A5;
        op(1'b1, 32'h83, 2'h1, 1'b1, 1'b0);
        `CHK(qd.size(), 1)
        if (qd.size() > 0) `CHK(qd[0], 16'hA5A5)
        ackDelay = 4'h0;
        $display("t_write done");
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK(reqReady, 1'b1)
        `CHK(addr_valid_strobe_n, 1'b1)
        t_sync_long();
        t_async_byte_port();
        t_misalign();
        t_fast();
        t_fault();
        t_write();
        complete_run();
    end
endmodule
